// File: design/packed_int_horizontal_abs_madd.sv
// Overview of operation
// - wrapping word hadd: sum adjacent signed word pairs, keep low 16 bits
// - saturating word hadd: sum adjacent signed word pairs, clamp to signed 16-bit
// - dword hadd: sum adjacent signed 32-bit pairs into packed 32-bit sums
// - wrapping word hsub: lower element minus upper element, 16-bit difference
// - saturating word hsub: lower minus upper word, clamped to signed 16-bit
// - dword hsub: lower minus upper dword, packed 32-bit differences
// - all operations work at 64-bit and 128-bit operand widths
// - absolute value on signed bytes, words and dwords, each element alone
// - absolute results are unsigned, most negative input gives its magnitude
// - madd: unsigned dst byte times signed src byte gives signed 16-bit product
// - madd: add adjacent products, clamp to signed 16-bit, pack words
`timescale 1ns/1ps
module packed_int_horizontal_abs_madd (
	input  wire logic                 clk,
	input  wire logic                 rst_n,
	input  wire logic                 req_valid,
	input  wire simd_pkg::simd_req_s  req,
	output logic                      rsp_valid,
	output simd_pkg::simd_rsp_s       rsp
);
	localparam int W  = simd_pkg::WIDE_W;
	localparam int NW = simd_pkg::NARROW_W;
	localparam int HW = simd_pkg::WORD_W;
	localparam int DW = simd_pkg::DWORD_W;
	localparam int BW = simd_pkg::BYTE_W;
	localparam int RW = $bits(simd_pkg::simd_rsp_s);

	// the slicing below assumes these element and operand sizes
	if (W != 2 * NW) begin : g_chk_narrow
		$error("wide width must be twice the narrow width");
	end
	if (NW % (2 * DW) != 0) begin : g_chk_pairs
		$error("narrow width must hold whole dword pairs");
	end
	if (DW != 2 * HW || HW != 2 * BW) begin : g_chk_elems
		$error("element sizes must double from byte to dword");
	end
	if (RW != W + 1) begin : g_chk_rsp
		$error("response must be the data plus the width flag");
	end

	// clamp a 17-bit signed sum to the signed 16-bit range
	function automatic logic [HW-1:0] sat16(input logic signed [HW:0] v);
		if (v > $signed({2'b00, {(HW-1){1'b1}}})) begin
			sat16 = {1'b0, {(HW-1){1'b1}}};
		end else if (v < $signed({2'b11, {(HW-1){1'b0}}})) begin
			sat16 = {1'b1, {(HW-1){1'b0}}};
		end else begin
			sat16 = v[HW-1:0];
		end
	endfunction

	// pair op on two signed words: add or lower minus upper, 17-bit exact
	function automatic logic signed [HW:0] pair16(input logic [2*HW-1:0] p, input logic sub);
		logic signed [HW:0] lo;
		logic signed [HW:0] hi;
		lo = {p[HW-1], p[HW-1:0]};
		hi = {p[2*HW-1], p[2*HW-1:HW]};
		pair16 = sub ? lo - hi : lo + hi;
	endfunction

	function automatic logic [DW-1:0] pair32(input logic [2*DW-1:0] p, input logic sub);
		pair32 = sub ? p[DW-1:0] - p[2*DW-1:DW] : p[DW-1:0] + p[2*DW-1:DW];
	endfunction

	// narrow form uses only the low half of each operand
	function automatic logic [W-1:0] fit_width(input logic [W-1:0] v, input logic wide);
		fit_width = wide ? v : {{NW{1'b0}}, v[NW-1:0]};
	endfunction

	// horizontal subtract forms take lower minus upper
	function automatic logic op_is_sub(input simd_pkg::simd_op_e o);
		op_is_sub = (o == simd_pkg::OP_HSUB_WORDS_WRAP) || (o == simd_pkg::OP_HSUB_WORDS_SAT)
			|| (o == simd_pkg::OP_HSUB_DWORDS);
	endfunction

	logic [W-1:0]  dst_v;
	logic [W-1:0]  src_v;
	logic [W-1:0]  res;
	logic          is_sub;
	simd_pkg::simd_op_e op;

	always_comb begin
		dst_v = fit_width(req.dst, req.wide);
		src_v = fit_width(req.src, req.wide);
		op = req.op;
		is_sub = op_is_sub(req.op);
	end

	logic [W-1:0] hw_wrap;
	logic [W-1:0] hw_sat;
	logic [W-1:0] hd;
	logic [W-1:0] ab;
	logic [W-1:0] aw;
	logic [W-1:0] ad;
	logic [W-1:0] madd;

	always_comb begin
		logic signed [HW:0] s;
		logic [2*HW-1:0] pr;
		logic [2*DW-1:0] pd;
		int nh;
		int nd;
		s = '0;
		pr = '0;
		pd = '0;
		hw_wrap = '0;
		hw_sat = '0;
		hd = '0;
		nh = req.wide ? W / (2 * HW) : NW / (2 * HW);
		nd = req.wide ? W / (2 * DW) : NW / (2 * DW);
		// dst pairs fill the lower half, src pairs the upper half
		for (int i = 0; i < W / (2 * HW); i++) begin
			if (i < nh) begin
				pr = dst_v[i*2*HW +: 2*HW];
				s = pair16(pr, is_sub);
				hw_wrap[i*HW +: HW] = s[HW-1:0];
				hw_sat[i*HW +: HW] = sat16(s);
				pr = src_v[i*2*HW +: 2*HW];
				s = pair16(pr, is_sub);
				hw_wrap[(i+nh)*HW +: HW] = s[HW-1:0];
				hw_sat[(i+nh)*HW +: HW] = sat16(s);
			end
		end
		for (int i = 0; i < W / (2 * DW); i++) begin
			if (i < nd) begin
				pd = dst_v[i*2*DW +: 2*DW];
				hd[i*DW +: DW] = pair32(pd, is_sub);
				pd = src_v[i*2*DW +: 2*DW];
				hd[(i+nd)*DW +: DW] = pair32(pd, is_sub);
			end
		end
	end

	// negation of the most negative value wraps to its own unsigned magnitude
	function automatic logic [BW-1:0] abs8(input logic [BW-1:0] v);
		abs8 = v[BW-1] ? -v : v;
	endfunction

	function automatic logic [HW-1:0] abs16(input logic [HW-1:0] v);
		abs16 = v[HW-1] ? -v : v;
	endfunction

	function automatic logic [DW-1:0] abs32(input logic [DW-1:0] v);
		abs32 = v[DW-1] ? -v : v;
	endfunction

	always_comb begin
		for (int i = 0; i < W / BW; i++) begin
			ab[i*BW +: BW] = abs8(src_v[i*BW +: BW]);
		end
		for (int i = 0; i < W / HW; i++) begin
			aw[i*HW +: HW] = abs16(src_v[i*HW +: HW]);
		end
		for (int i = 0; i < W / DW; i++) begin
			ad[i*DW +: DW] = abs32(src_v[i*DW +: DW]);
		end
	end

	// unsigned byte times signed byte, exact in a signed word
	function automatic logic signed [HW-1:0] mul_us8(input logic [BW-1:0] u,
			input logic [BW-1:0] v);
		mul_us8 = $signed({1'b0, u}) * $signed(v);
	endfunction

	always_comb begin
		logic signed [HW-1:0] p0;
		logic signed [HW-1:0] p1;
		logic signed [HW:0]   sm;
		p0 = '0;
		p1 = '0;
		sm = '0;
		madd = '0;
		for (int i = 0; i < W / HW; i++) begin
			p0 = mul_us8(dst_v[i*HW +: BW], src_v[i*HW +: BW]);
			p1 = mul_us8(dst_v[i*HW+BW +: BW], src_v[i*HW+BW +: BW]);
			sm = {p0[HW-1], p0} + {p1[HW-1], p1};
			madd[i*HW +: HW] = sat16(sm);
		end
	end

	always_comb begin
		// undefined op codes give a zero result
		case (op)
			simd_pkg::OP_HADD_WORDS_WRAP, simd_pkg::OP_HSUB_WORDS_WRAP: res = hw_wrap;
			simd_pkg::OP_HADD_WORDS_SAT, simd_pkg::OP_HSUB_WORDS_SAT:   res = hw_sat;
			simd_pkg::OP_HADD_DWORDS, simd_pkg::OP_HSUB_DWORDS:         res = hd;
			simd_pkg::OP_ABS_BYTES:                                     res = ab;
			simd_pkg::OP_ABS_WORDS:                                     res = aw;
			simd_pkg::OP_ABS_DWORDS:                                    res = ad;
			simd_pkg::OP_MUL_ADD_UNSIGNED_SIGNED_BYTES:                 res = madd;
			default:                                                    res = '0;
		endcase
		if (!req.wide) begin
			res[W-1:NW] = '0;
		end
	end

	simd_pkg::simd_rsp_s rsp_d;
	logic [RW-1:0]       rsp_bits;

	always_comb begin
		rsp_d.wide = req.wide;
		rsp_d.data = res;
	end

	// one cycle of latency; the result holds while no request is taken
	simd_result_reg #(
		.W (RW)
	) u_result (
		.clk       (clk),
		.rst_n     (rst_n),
		.in_valid  (req_valid),
		.in_data   (rsp_d),
		.out_valid (rsp_valid),
		.out_data  (rsp_bits)
	);

	assign rsp = simd_pkg::simd_rsp_s'(rsp_bits);
endmodule

// File: design/simd_pkg.sv
package simd_pkg;

	localparam int WIDE_W   = 128;
	localparam int NARROW_W = 64;
	localparam int BYTE_W   = 8;
	localparam int WORD_W   = 16;
	localparam int DWORD_W  = 32;

	typedef enum logic [3:0] {
		OP_HADD_WORDS_WRAP,
		OP_HADD_WORDS_SAT,
		OP_HADD_DWORDS,
		OP_HSUB_WORDS_WRAP,
		OP_HSUB_WORDS_SAT,
		OP_HSUB_DWORDS,
		OP_ABS_BYTES,
		OP_ABS_WORDS,
		OP_ABS_DWORDS,
		OP_MUL_ADD_UNSIGNED_SIGNED_BYTES
	} simd_op_e;

	typedef struct packed {
		simd_op_e            op;
		logic                wide;
		logic [WIDE_W-1:0]   dst;
		logic [WIDE_W-1:0]   src;
	} simd_req_s;

	typedef struct packed {
		logic                wide;
		logic [WIDE_W-1:0]   data;
	} simd_rsp_s;

endpackage

// File: design/simd_result_reg.sv
`timescale 1ns/1ps
module simd_result_reg #(
	parameter int W = 129
) (
	input  wire logic         clk,
	input  wire logic         rst_n,
	input  wire logic         in_valid,
	input  wire logic [W-1:0] in_data,
	output logic              out_valid,
	output logic [W-1:0]      out_data
);
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			out_valid <= 1'b0;
		end else begin
			out_valid <= in_valid;
		end
	end

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			out_data <= '0;
		end else if (in_valid) begin
			out_data <= in_data;
		end
	end
endmodule

// File: tb/simd_decode.sv
`timescale 1ns/1ps
module simd_decode (
	input  wire logic           clk,
	output simd_pkg::simd_req_s req,
	output logic                req_valid
);
	initial {req_valid, req} = '0;
	// an idle request shows the inverse of the last one
	task automatic send(input logic v, input simd_pkg::simd_req_s x);
		@(posedge clk);
		req_valid <= v;
		req <= v ? x : ~req;
	endtask
endmodule

// File: tb/simd_props.sv
`timescale 1ns/1ps
module simd_props (
	input wire logic                clk,
	input wire logic                rst_n,
	input wire logic                req_valid,
	input wire simd_pkg::simd_req_s req,
	input wire logic                rsp_valid,
	input wire simd_pkg::simd_rsp_s rsp
);
	default clocking cb @(posedge clk);
	endclocking
	default disable iff (!rst_n);
	property p_lat; req_valid |=> rsp_valid && rsp.wide == $past(req.wide); endproperty
	a_lat: assert property (p_lat) else $error("late");
	property p_gap; !req_valid |=> !rsp_valid && $stable(rsp); endproperty
	a_gap: assert property (p_gap) else $error("extra");
	property p_nar; req_valid && !req.wide |=> !rsp.data[127:64]; endproperty
	a_nar: assert property (p_nar) else $error("upper");
	property p_haw; req_valid && req.op == 4'h0 |=>
		rsp.data[15:0] == $past(req.dst[15:0]) + $past(req.dst[31:16]); endproperty
	a_haw: assert property (p_haw) else $error("sum");
	property p_hsd; req_valid && req.op == 4'h5 |=>
		rsp.data[31:0] == $past(req.dst[31:0]) - $past(req.dst[63:32]); endproperty
	a_hsd: assert property (p_hsd) else $error("diff");
	property p_hsw; req_valid && req.op == 4'h4 && req.dst[31:0] == 32'h7fff8000 |=>
		rsp.data[15:0] == 16'h8000; endproperty
	a_hsw: assert property (p_hsw) else $error("clamp");
	property p_abs; req_valid && req.op == 4'h6 && req.src[7:0] == 8'h80 |=>
		rsp.data[7:0] == 8'h80; endproperty
	a_abs: assert property (p_abs) else $error("abs");
	property p_mad; req_valid && req.op == 4'h9 && req.src[15:0] == 16'h8080 &&
		req.dst[15:0] == 16'hffff |=> rsp.data[15:0] == 16'h8000; endproperty
	a_mad: assert property (p_mad) else $error("madd");
	c_mad: cover property (req_valid && req.op == 4'h9);
	c_b2b: cover property (req_valid [*2]);
	c_nar: cover property (req_valid && !req.wide);
	c_und: cover property (req_valid && req.op > 4'h9);
endmodule
bind packed_int_horizontal_abs_madd simd_props u_props (.clk(clk), .rst_n(rst_n),
	.req_valid(req_valid), .req(req), .rsp_valid(rsp_valid), .rsp(rsp));

// File: tb/testbench.sv
`timescale 1ns/1ps
module testbench;
	logic                clk, rst_n, req_valid, rsp_valid;
	simd_pkg::simd_req_s req, r;
	simd_pkg::simd_rsp_s rsp;
	logic [128:0]        q[$];
	logic [127:0]        c[4];
	int                  err_total, n_checks, seed = 32'h08f61ea8;
	simd_decode u_drv (.clk(clk), .req(req), .req_valid(req_valid));
	packed_int_horizontal_abs_madd dut (.clk(clk), .rst_n(rst_n), .req_valid(req_valid),
		.req(req), .rsp_valid(rsp_valid), .rsp(rsp));
	function automatic logic signed [33:0] sx(logic [127:0] x, int sz);
		return 34'(x % (128'h1 << sz) ^ 128'h1 << sz - 1) - (34'h1 << sz - 1);
	endfunction
	function automatic logic [127:0] exp_f(simd_pkg::simd_req_s x);
		logic signed [33:0] a, b, t;
		int                 o, n, sz;
		exp_f = '0;
		o = x.op;
		sz = o == 2 || o == 5 ? 32 : o < 6 || o > 8 ? 16 : 8 << o - 6;
		n = (x.wide ? 128 : 64) / sz;
		for (int k = 0; k < n; k++) begin
			a = sx((k < n / 2 ? x.dst : x.src) >> 2 * k % n * sz, sz);
			b = sx((k < n / 2 ? x.dst : x.src) >> (2 * k % n + 1) * sz, sz);
			t = o > 2 ? a - b : a + b;
			a = sx(x.src >> k * sz, sz);
			if (o > 5)
				t = a < 0 ? -a : a;
			if (o == 9)
				t = 34'(x.dst >> 16 * k & 8'hff) * sx(x.src >> 16 * k, 8)
					+ 34'(x.dst >> 16 * k + 8 & 8'hff) * sx(x.src >> 16 * k + 8, 8);
			if (o == 1 || o == 4 || o == 9)
				t = t > 34'sh7fff ? 34'sh7fff : t < -34'sh8000 ? -34'sh8000 : t;
			if (o > 9)
				t = '0;
			exp_f |= (128'(t) & (128'h1 << sz) - 1) << k * sz;
		end
	endfunction
	task automatic chk(logic [128:0] g, logic [128:0] e);
		n_checks++;
		if (g !== e) begin
			err_total++;
			$display("mismatch %0t got %h want %h", $time, g, e);
		end
	endtask
	task automatic test_done();
		$display("checks %0d mismatches %0d", n_checks, err_total);
		if (err_total == 0 && n_checks > 0)
			$display("Finished cleanly");
		else
			$display("Finished with errors");
		$finish;
	endtask
	initial begin
		clk = 1'b0;
		forever #10 clk = ~clk;
	end
	always @(posedge clk)
		if (rsp_valid === 1'b1)
			chk(rsp, q.size() ? q.pop_front() : ~rsp);
	initial begin
		rst_n = 1'b0;
		c = '{{16{8'h80}}, {16{8'h7f}}, {4{32'h7fff8000}}, {16{8'hff}}};
		repeat (3) @(posedge clk);
		rst_n <= 1'b1;
		for (int i = 0; i < 720; i++) begin
			r.op = simd_pkg::simd_op_e'(i < 320 ? i / 32 : $unsigned($random(seed)) % 16);
			r.wide = i[0];
			r.dst = i < 320 ? c[i[2:1]] : {$random(seed), $random(seed), $random(seed), $random(seed)};
			r.src = i < 320 ? c[i[4:3]] : {$random(seed), $random(seed), $random(seed), $random(seed)};
			u_drv.send(1'b1, r);
			q.push_back({r.wide, exp_f(r)});
			if (i == 319) begin
				$display("corner test done");
				u_drv.send(1'b0, r);
				@(posedge clk);
				rst_n <= 1'b0;
				@(posedge clk);
				chk(rsp, '0);
				rst_n <= 1'b1;
				$display("reset test done");
			end
		end
		u_drv.send(1'b0, r);
		repeat (3) @(posedge clk);
		chk(q.size(), 0);
		$display("random test done");
		test_done();
	end
	initial begin
		#40000;
		err_total++;
		test_done();
	end
endmodule
